// ---- core/nfc_host.sv ----
// Host controller sequencing command, address and data cycles to a NAND flash
//
// Function
// - Program/read of a set byte count from any column, whole-block erase
// - Commands, addresses, data share eight I/O lines
// - Values latched on write strobe rise, chip selected
// - CLE marks commands, ALE marks addresses
// - Two column then three row address cycles
// - Page read and program take five addresses
// - Erase takes only three row cycles
// - Read is 00h, address, 30h
// - Copy-back: 00h/35h read, 85h/10h program
// - Program 80h; 10h normal, 15h cache
// - Erase is 60h, rows, D0h
// - Column move: 85h in, 05h/E0h out
// - While busy only reset or status allowed
// - Only defined command codes are sent
// - Unused high address bits driven low
`timescale 1ns/1ps
module nfc_host (
	input  wire logic                    clk_sys_in,
	input  wire logic                    resetn_in,
	input  wire logic                    cmd_valid_in,
	input  wire nfc_pkg::nfc_op_t        cmd_op_in,
	input  wire logic [11:0]             cmd_col_in,
	input  wire logic [17:0]             cmd_row_in,
	input  wire logic [11:0]             cmd_len_in,
	input  wire logic                    cmd_more_in,
	output logic                         cmd_ready_out,
	output logic                         cmd_refused_out,
	output logic                         done_out,
	input  wire logic                    wr_valid_in,
	input  wire logic [7:0]              wr_data_in,
	input  wire logic                    wr_last_in,
	output logic                         wr_ready_out,
	output logic                         rd_valid_out,
	output logic [7:0]                   rd_data_out,
	output logic                         dev_busy_out,
	input  wire logic [7:0]              nand_io_in,
	output logic [7:0]                   nand_io_out,
	output logic                         nand_io_oe_out,
	output logic                         nand_cle_out,
	output logic                         nand_ale_out,
	output logic                         nand_ce_n_out,
	output logic                         nand_we_n_out,
	output logic                         output_strobe_n_out,
	output logic                         nand_wp_n_out,
	input  wire logic                    nand_rb_n_in
);
	localparam logic [3:0] WR_LAST = nfc_pkg::WR_LOW_CYC + nfc_pkg::WR_HIGH_CYC - 4'h1;
	localparam logic [3:0] RD_LAST = nfc_pkg::RD_LOW_CYC + nfc_pkg::RD_HIGH_CYC - 4'h1;

	logic [8:0] pins_s;
	logic [7:0] io_s;
	logic       rb_n_s;

	nfc_sync2 #(.W(9)) u_sync (
		.clk_sys_in   (clk_sys_in),
		.resetn_in    (resetn_in),
		.async_in     ({nand_rb_n_in, nand_io_in}),
		.reset_val_in (9'h100),
		.sync_out     (pins_s)
	);
	assign io_s   = pins_s[7:0];
	assign rb_n_s = pins_s[8];

	nfc_pkg::nfc_state_t st_q, st_d;
	nfc_pkg::nfc_op_t    op_q, op_d;
	logic        act_q, act_d, rd_q, rd_d, last_q, last_d, skip_q, skip_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [2:0]  aidx_q, aidx_d, aleft_q, aleft_d;
	logic [11:0] col_q, col_d, len_q, len_d;
	logic [17:0] row_q, row_d;
	logic [7:0]  c2_q, c2_d, pend_q, pend_d, io_q, io_d, rdat_q, rdat_d;
	logic        rdy_q, rdy_d, ref_q, ref_d, done_q, done_d, wrdy_q, wrdy_d, rval_q, rval_d;
	logic        busy_q, busy_d, oe_q, oe_d, cle_q, cle_d, ale_q, ale_d;
	logic        ce_n_q, ce_n_d, we_n_q, we_n_d, re_n_q, re_n_d, wp_n_q, wp_n_d;
	logic        end_c;
	logic [7:0]  abyte;

	// Address bytes, column low first, unused high bits forced low
	always_comb begin
		unique case (aidx_q)
			3'h0:    abyte = col_q[7:0];
			3'h1:    abyte = {4'h0, col_q[11:8]};
			3'h2:    abyte = row_q[7:0];
			3'h3:    abyte = row_q[15:8];
			default: abyte = {6'h00, row_q[17:16]};
		endcase
	end

	assign end_c = act_q && (cnt_q == (rd_q ? RD_LAST : WR_LAST));

	always_comb begin
		st_d = st_q; op_d = op_q; act_d = act_q; rd_d = rd_q; last_d = last_q; skip_d = skip_q;
		cnt_d = cnt_q; aidx_d = aidx_q; aleft_d = aleft_q; col_d = col_q; len_d = len_q; row_d = row_q;
		c2_d = c2_q; pend_d = pend_q; io_d = io_q; rdat_d = rdat_q;
		rdy_d = 1'b0; ref_d = 1'b0; done_d = 1'b0; wrdy_d = 1'b0; rval_d = 1'b0;
		busy_d = !rb_n_s;
		wp_n_d = 1'b1;
		if (act_q) begin
			cnt_d = cnt_q + 4'h1;
		end
		if (end_c) begin
			act_d = 1'b0;
			cnt_d = 4'h0;
		end
		unique case (st_q)
			nfc_pkg::ST_IDLE: begin
				rdy_d = 1'b1;
				if (cmd_valid_in && rdy_q) begin
					// Busy device takes nothing but reset and status
					if (busy_q && cmd_op_in != nfc_pkg::OP_RESET && cmd_op_in != nfc_pkg::OP_STATUS) begin
						ref_d = 1'b1;
					end else begin
						rdy_d = 1'b0;
						op_d = cmd_op_in;
						col_d = (cmd_op_in == nfc_pkg::OP_READ_ID) ? 12'h000 : cmd_col_in;
						row_d = cmd_row_in;
						len_d = (cmd_len_in == 12'h000 || cmd_op_in == nfc_pkg::OP_STATUS) ? 12'h001 : cmd_len_in;
						aidx_d = (cmd_op_in == nfc_pkg::OP_ERASE) ? 3'h2 : 3'h0;
						aleft_d = nfc_pkg::op_naddr(cmd_op_in);
						skip_d = cmd_more_in && nfc_pkg::op_deferrable(cmd_op_in);
						// Random input inherits the confirm of the open program
						c2_d = (cmd_op_in == nfc_pkg::OP_RAND_IN) ? pend_q : nfc_pkg::op_cmd2(cmd_op_in);
						if (nfc_pkg::op_deferrable(cmd_op_in) && cmd_op_in != nfc_pkg::OP_RAND_IN) begin
							pend_d = nfc_pkg::op_cmd2(cmd_op_in);
						end
						io_d = nfc_pkg::op_cmd1(cmd_op_in);
						st_d = nfc_pkg::ST_CMD1;
						act_d = 1'b1;
						rd_d = 1'b0;
						cnt_d = 4'h0;
					end
				end
			end
			nfc_pkg::ST_CMD1, nfc_pkg::ST_ADDR, nfc_pkg::ST_DIN, nfc_pkg::ST_CMD2: begin
				if (st_q == nfc_pkg::ST_DIN && !act_q) begin
					wrdy_d = 1'b1;
					if (wr_valid_in && wrdy_q) begin
						wrdy_d = 1'b0;
						io_d = wr_data_in;
						last_d = wr_last_in;
						act_d = 1'b1;
						rd_d = 1'b0;
						cnt_d = 4'h0;
					end
				end
				if (end_c) begin
					if (st_q == nfc_pkg::ST_ADDR) begin
						aleft_d = aleft_q - 3'h1;
					end
					if (st_q == nfc_pkg::ST_DIN && !last_q) begin
						wrdy_d = 1'b1;
					end else if ((st_q == nfc_pkg::ST_CMD1 && aleft_q != 3'h0)
							|| (st_q == nfc_pkg::ST_ADDR && aleft_q > 3'h1)) begin
						st_d = nfc_pkg::ST_ADDR;
						io_d = abyte;
						aidx_d = aidx_q + 3'h1;
						act_d = 1'b1;
						cnt_d = 4'h0;
					end else if (st_q != nfc_pkg::ST_CMD2 && st_q != nfc_pkg::ST_DIN
							&& nfc_pkg::op_has_din(op_q)) begin
						st_d = nfc_pkg::ST_DIN;
						last_d = 1'b0;
					end else if (st_q != nfc_pkg::ST_CMD2 && c2_q != nfc_pkg::CMD_NONE && !skip_q) begin
						st_d = nfc_pkg::ST_CMD2;
						io_d = c2_q;
						act_d = 1'b1;
						cnt_d = 4'h0;
					end else if (nfc_pkg::op_waits(op_q) && !skip_q && op_q != nfc_pkg::OP_RAND_IN
							|| (op_q == nfc_pkg::OP_RAND_IN && st_q == nfc_pkg::ST_CMD2)) begin
						st_d = nfc_pkg::ST_WAITB;
					end else if (nfc_pkg::op_has_dout(op_q)) begin
						st_d = nfc_pkg::ST_DOUT;
						act_d = 1'b1;
						rd_d = 1'b1;
						cnt_d = 4'h0;
					end else begin
						st_d = nfc_pkg::ST_IDLE;
						done_d = 1'b1;
					end
				end
			end
			nfc_pkg::ST_WAITB: begin
				// Busy pin is only trusted after the device had time to pull it
				cnt_d = (cnt_q < nfc_pkg::WB_CYC) ? cnt_q + 4'h1 : cnt_q;
				if (cnt_q >= nfc_pkg::WB_CYC && !busy_q) begin
					cnt_d = 4'h0;
					if (op_q == nfc_pkg::OP_READ) begin
						st_d = nfc_pkg::ST_DOUT;
						act_d = 1'b1;
						rd_d = 1'b1;
					end else begin
						st_d = nfc_pkg::ST_IDLE;
						done_d = 1'b1;
					end
				end
			end
			nfc_pkg::ST_DOUT: begin
				if (end_c) begin
					// Synced pins lag two edges, so this is the byte of the low phase
					rval_d = 1'b1;
					rdat_d = io_s;
					len_d = len_q - 12'h001;
					if (len_q == 12'h001) begin
						st_d = nfc_pkg::ST_IDLE;
						done_d = 1'b1;
					end else begin
						act_d = 1'b1;
						cnt_d = 4'h0;
					end
				end
			end
			default: begin
				st_d = nfc_pkg::ST_IDLE;
				act_d = 1'b0;
			end
		endcase
		oe_d = act_d && !rd_d;
		we_n_d = !(act_d && !rd_d && cnt_d < nfc_pkg::WR_LOW_CYC);
		re_n_d = !(act_d && rd_d && cnt_d < nfc_pkg::RD_LOW_CYC);
		cle_d = act_d && (st_d == nfc_pkg::ST_CMD1 || st_d == nfc_pkg::ST_CMD2);
		ale_d = act_d && st_d == nfc_pkg::ST_ADDR;
		ce_n_d = (st_d == nfc_pkg::ST_IDLE);
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= nfc_pkg::ST_IDLE; op_q <= nfc_pkg::OP_STATUS;
			act_q <= 1'b0; rd_q <= 1'b0; last_q <= 1'b0; skip_q <= 1'b0; cnt_q <= 4'h0;
			aidx_q <= 3'h0; aleft_q <= 3'h0; col_q <= 12'h000; len_q <= 12'h000; row_q <= 18'h00000;
			c2_q <= 8'h00; pend_q <= nfc_pkg::CMD_PROG_EXEC; io_q <= 8'h00; rdat_q <= 8'h00;
			rdy_q <= 1'b0; ref_q <= 1'b0; done_q <= 1'b0; wrdy_q <= 1'b0; rval_q <= 1'b0; busy_q <= 1'b0;
			oe_q <= 1'b0; cle_q <= 1'b0; ale_q <= 1'b0; ce_n_q <= 1'b1; we_n_q <= 1'b1; re_n_q <= 1'b1;
			wp_n_q <= 1'b0;
		end else begin
			st_q <= st_d; op_q <= op_d;
			act_q <= act_d; rd_q <= rd_d; last_q <= last_d; skip_q <= skip_d; cnt_q <= cnt_d;
			aidx_q <= aidx_d; aleft_q <= aleft_d; col_q <= col_d; len_q <= len_d; row_q <= row_d;
			c2_q <= c2_d; pend_q <= pend_d; io_q <= io_d; rdat_q <= rdat_d;
			rdy_q <= rdy_d; ref_q <= ref_d; done_q <= done_d; wrdy_q <= wrdy_d; rval_q <= rval_d; busy_q <= busy_d;
			oe_q <= oe_d; cle_q <= cle_d; ale_q <= ale_d; ce_n_q <= ce_n_d; we_n_q <= we_n_d; re_n_q <= re_n_d;
			wp_n_q <= wp_n_d;
		end
	end

	assign cmd_ready_out       = rdy_q;
	assign cmd_refused_out     = ref_q;
	assign done_out            = done_q;
	assign wr_ready_out        = wrdy_q;
	assign rd_valid_out        = rval_q;
	assign rd_data_out         = rdat_q;
	assign dev_busy_out        = busy_q;
	assign nand_io_out         = io_q;
	assign nand_io_oe_out      = oe_q;
	assign nand_cle_out        = cle_q;
	assign nand_ale_out        = ale_q;
	assign nand_ce_n_out       = ce_n_q;
	assign nand_we_n_out       = we_n_q;
	assign output_strobe_n_out = re_n_q;
	assign nand_wp_n_out       = wp_n_q;

	// Bus history seen by the device, read only by the checks below
	logic [7:0] hist_cmd_q;
	logic [2:0] hist_addr_q;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hist_cmd_q <= 8'h00;
			hist_addr_q <= 3'h0;
		end else if (we_n_d && !we_n_q && cle_q) begin
			hist_cmd_q <= io_q;
			hist_addr_q <= 3'h0;
		end else if (we_n_d && !we_n_q && ale_q && hist_addr_q != 3'h7) begin
			hist_addr_q <= hist_addr_q + 3'h1;
		end
	end

	sequence s_we_low;
		(!nand_we_n_out) [*3] ##1 nand_we_n_out;
	endsequence

	a_we_low_width: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		$fell(nand_we_n_out) |-> s_we_low) else $error("write strobe low time wrong");
	a_we_high_gap: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		$rose(nand_we_n_out) |-> nand_we_n_out [*2]) else $error("write strobe high time too short");
	a_we_needs_ce: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		!nand_we_n_out |-> !nand_ce_n_out && nand_io_oe_out && $stable(nand_io_out) || $fell(nand_we_n_out))
		else $error("write strobe without select or with moving data");
	a_cle_ale_excl: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		!(nand_cle_out && nand_ale_out)) else $error("command and address latch both high");
	a_codes_known: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		nand_cle_out && !nand_we_n_out |-> nand_io_out inside {8'h00, 8'h30, 8'h35, 8'h90, 8'hFF, 8'h80,
		8'h10, 8'h15, 8'h85, 8'h60, 8'hD0, 8'h05, 8'hE0, 8'h70}) else $error("undefined command code");
	a_read_exec_order: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		nand_cle_out && !nand_we_n_out && nand_io_out inside {8'h30, 8'h35}
		|-> hist_cmd_q == 8'h00 && hist_addr_q == 3'h5) else $error("read confirm out of order");
	a_erase_order: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		nand_cle_out && !nand_we_n_out && nand_io_out == 8'hD0
		|-> hist_cmd_q == 8'h60 && hist_addr_q == 3'h3) else $error("erase confirm out of order");
	a_prog_confirm: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		nand_cle_out && !nand_we_n_out && nand_io_out inside {8'h10, 8'h15}
		|-> hist_cmd_q inside {8'h80, 8'h85}) else $error("program confirm without setup");
	a_rand_out_order: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		nand_cle_out && !nand_we_n_out && nand_io_out == 8'hE0
		|-> hist_cmd_q == 8'h05 && hist_addr_q == 3'h2) else $error("random output confirm out of order");
	a_addr_high_low: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		nand_ale_out && !nand_we_n_out && hist_addr_q == 3'h4 |-> nand_io_out[7:2] == 6'h00)
		else $error("unused address bits not low");
	a_busy_only_safe: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		$rose(nand_cle_out) && $past(dev_busy_out) |-> nand_io_out inside {8'hFF, 8'h70})
		else $error("command other than reset or status while busy");
	a_re_we_excl: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
		!output_strobe_n_out |-> nand_we_n_out && !nand_io_oe_out) else $error("read strobe while driving bus");
endmodule

// ---- core/nfc_pkg.sv ----
// Constants, types and decode functions of the NAND command-sequencing controller
package nfc_pkg;

	localparam int CLK_MHZ = 100;

	// Strobe timing, in ns as specified, and derived clock counts (round up)
	localparam int T_WR_LOW_NS = 25;
	localparam int T_WR_HIGH_NS = 15;
	localparam int T_RD_LOW_NS = 30;
	localparam int T_RD_HIGH_NS = 20;
	localparam int T_WB_NS = 100;
	localparam logic [3:0] WR_LOW_CYC = 4'((T_WR_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WR_HIGH_CYC = 4'((T_WR_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] RD_LOW_CYC = 4'((T_RD_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] RD_HIGH_CYC = 4'((T_RD_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WB_CYC = 4'((T_WB_NS * CLK_MHZ + 999) / 1000);

	// Array geometry of the byte-wide part
	localparam int IO_W = 8;
	localparam int COL_W = 12;
	localparam int ROW_W = 18;
	localparam int LEN_W = 12;
	localparam int PAGES = 262144;
	localparam int PAGE_BYTES = 2112;
	localparam int SPARE_FIRST_COL = 2048;
	localparam int SPARE_LAST_COL = 2111;
	localparam int BLOCKS = 4096;

	// Command codes
	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_READ_EXEC = 8'h30;
	localparam logic [7:0] CMD_READ_COPY = 8'h35;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
	localparam logic [7:0] CMD_PROG_EXEC = 8'h10;
	localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
	localparam logic [7:0] CMD_COPY_SETUP = 8'h85;
	localparam logic [7:0] CMD_RAND_IN = 8'h85;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_EXEC = 8'hD0;
	localparam logic [7:0] CMD_RAND_OUT_SETUP = 8'h05;
	localparam logic [7:0] CMD_RAND_OUT_EXEC = 8'hE0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_NONE = 8'h00;

	typedef enum logic [3:0] {
		OP_READ       = 4'h0,
		OP_READ_COPY  = 4'h1,
		OP_READ_ID    = 4'h2,
		OP_RESET      = 4'h3,
		OP_PROG       = 4'h4,
		OP_PROG_CACHE = 4'h5,
		OP_COPY_PROG  = 4'h6,
		OP_ERASE      = 4'h7,
		OP_RAND_IN    = 4'h8,
		OP_RAND_OUT   = 4'h9,
		OP_STATUS     = 4'hA
	} nfc_op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_CMD1  = 3'h1,
		ST_ADDR  = 3'h3,
		ST_DIN   = 3'h2,
		ST_CMD2  = 3'h6,
		ST_WAITB = 3'h7,
		ST_DOUT  = 3'h5
	} nfc_state_t;

	// Leading command of each operation; only defined codes can come out
	function automatic logic [7:0] op_cmd1(input nfc_op_t op);
		unique case (op)
			OP_READ, OP_READ_COPY: op_cmd1 = CMD_READ_SETUP;
			OP_READ_ID:            op_cmd1 = CMD_READ_ID;
			OP_RESET:              op_cmd1 = CMD_RESET;
			OP_PROG, OP_PROG_CACHE: op_cmd1 = CMD_PROG_SETUP;
			OP_COPY_PROG:          op_cmd1 = CMD_COPY_SETUP;
			OP_ERASE:              op_cmd1 = CMD_ERASE_SETUP;
			OP_RAND_IN:            op_cmd1 = CMD_RAND_IN;
			OP_RAND_OUT:           op_cmd1 = CMD_RAND_OUT_SETUP;
			default:               op_cmd1 = CMD_STATUS;
		endcase
	endfunction

	// Confirm command, CMD_NONE where the operation has none
	function automatic logic [7:0] op_cmd2(input nfc_op_t op);
		unique case (op)
			OP_READ:                 op_cmd2 = CMD_READ_EXEC;
			OP_READ_COPY:            op_cmd2 = CMD_READ_COPY;
			OP_PROG, OP_COPY_PROG:   op_cmd2 = CMD_PROG_EXEC;
			OP_PROG_CACHE:           op_cmd2 = CMD_PROG_CACHE;
			OP_ERASE:                op_cmd2 = CMD_ERASE_EXEC;
			OP_RAND_OUT:             op_cmd2 = CMD_RAND_OUT_EXEC;
			default:                 op_cmd2 = CMD_NONE;
		endcase
	endfunction

	function automatic logic [2:0] op_naddr(input nfc_op_t op);
		unique case (op)
			OP_READ, OP_READ_COPY, OP_PROG, OP_PROG_CACHE, OP_COPY_PROG: op_naddr = 3'h5;
			OP_ERASE:                op_naddr = 3'h3;
			OP_RAND_IN, OP_RAND_OUT: op_naddr = 3'h2;
			OP_READ_ID:              op_naddr = 3'h1;
			default:                 op_naddr = 3'h0;
		endcase
	endfunction

	function automatic logic op_has_din(input nfc_op_t op);
		op_has_din = (op == OP_PROG) || (op == OP_PROG_CACHE) || (op == OP_RAND_IN);
	endfunction

	function automatic logic op_has_dout(input nfc_op_t op);
		op_has_dout = (op == OP_READ) || (op == OP_READ_ID) || (op == OP_RAND_OUT) || (op == OP_STATUS);
	endfunction

	function automatic logic op_waits(input nfc_op_t op);
		op_waits = (op == OP_READ) || (op == OP_READ_COPY) || (op == OP_RESET) || (op == OP_PROG)
			|| (op == OP_PROG_CACHE) || (op == OP_COPY_PROG) || (op == OP_ERASE) || (op == OP_RAND_IN);
	endfunction

	// Program-type operations whose confirm can be held back for more data
	function automatic logic op_deferrable(input nfc_op_t op);
		op_deferrable = (op == OP_PROG) || (op == OP_PROG_CACHE) || (op == OP_COPY_PROG) || (op == OP_RAND_IN);
	endfunction

endpackage

// ---- core/nfc_sync2.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module nfc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_in,
	input  wire logic         resetn_in,
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] reset_val_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// Bits set in reset_val_in are stored inverted, so a zero reset reads as that level
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in ^ reset_val_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q ^ reset_val_in;
endmodule

// ---- verification/nfc_nand_model.sv ----
// Behavioural flash device: command decode, addressing, page store, ready/busy
`timescale 1ns/1ps
module nfc_nand_model #(
	parameter logic [7:0] ID_BYTE = 8'hA5, // Arbitrary identification value
	parameter bit         PRE_TIED = 1'b1, // power-on read pin tied high
	parameter int         BUSY_NS = 300,
	parameter int         HOLD_NS = 15
) (
	input  wire logic       ce_n_in,
	input  wire logic       cle_in,
	input  wire logic       ale_in,
	input  wire logic       we_n_in,
	input  wire logic       output_strobe_n_in,
	input  wire logic       rb_in,
	input  wire logic [7:0] io_in,
	output logic      [7:0] io_out,
	output logic            busy_out
);
	logic [7:0]  mem [int]; // sparse store of 2112-column pages
	logic [7:0]  cmd_q = PRE_TIED ? 8'h30 : 8'hFF; // page 0 streams out without a command
	logic [7:0]  last_q = 8'h00;
	logic [11:0] col_q = 12'h000;
	logic [17:0] row_q = 18'h00000, src_q = 18'h00000;
	logic        drv = 1'b0, copy_q = 1'b0;
	int          acnt = 0;
	event        start;
	initial busy_out = 1'b0;
	always @(start) begin
		busy_out = 1'b1;
		#BUSY_NS;
		busy_out = 1'b0;
	end
	always @(posedge we_n_in) begin
		if (ce_n_in === 1'b0 && cle_in === 1'b1) begin
			acnt = 0;
			if (!busy_out || io_in inside {8'hFF, 8'h70}) begin
				if (io_in == 8'h10 && cmd_q == 8'h85 && copy_q) // page moves inside the device
					for (int k = 0; k < 2112; k++)
						if (mem.exists({src_q, 12'(k)}))
							mem[{row_q, 12'(k)}] = mem[{src_q, 12'(k)}];
						else
							mem.delete({row_q, 12'(k)});
				for (int k = 0; k < 64 * 2112 && io_in == 8'hD0; k++) // all 64 pages of the block
					mem.delete({row_q[17:6], 6'(k / 2112), 12'(k % 2112)});
				copy_q = (io_in == 8'h35) || (copy_q && io_in == 8'h85);
				src_q = (io_in == 8'h35) ? row_q : src_q;
				cmd_q = io_in;
				col_q = (io_in == 8'h90) ? 12'h000 : col_q;
				if (io_in inside {8'h30, 8'h35, 8'h10, 8'h15, 8'hD0, 8'hFF})
					-> start;
			end
		end else if (ce_n_in === 1'b0 && ale_in === 1'b1) begin
			case (acnt + ((cmd_q == 8'h60) ? 2 : 0))
				0: col_q[7:0] = io_in;
				1: col_q[11:8] = io_in[3:0];
				2: row_q[7:0] = io_in;
				3: row_q[15:8] = io_in;
				4: row_q[17:16] = io_in[1:0];
				default: ;
			endcase
			acnt++;
		end else if (ce_n_in === 1'b0 && cmd_q inside {8'h80, 8'h85}) begin
			mem[{row_q, col_q}] = io_in;
			col_q++;
		end
	end
	always @(negedge output_strobe_n_in) begin
		if (ce_n_in === 1'b0) begin
			if (cmd_q == 8'h70)
				last_q = {1'b1, rb_in, 6'h00};
			else if (cmd_q == 8'h90)
				last_q = ID_BYTE + col_q[7:0];
			else
				last_q = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : col_q[7:0];
			col_q++;
			drv = 1'b1;
		end
	end
	// Output hold runs out after the strobe rises
	always @(posedge output_strobe_n_in or posedge ce_n_in) begin
		#HOLD_NS;
		drv = 1'b0;
	end
	// Released lines show the inverse, never a stale value
	assign io_out = drv ? last_q : ~last_q;
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench: host controller against the behavioural flash model
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] C1 [11] = '{8'h00, 8'h00, 8'h90, 8'hFF, 8'h80, 8'h80, 8'h85, 8'h60, 8'h85, 8'h05, 8'h70};
	localparam logic [7:0] C2 [11] = '{8'h30, 8'h35, 8'h00, 8'h00, 8'h10, 8'h15, 8'h10, 8'hD0, 8'h00, 8'hE0, 8'h00};
	localparam int         NA [11] = '{5, 5, 1, 0, 5, 5, 5, 3, 2, 2, 0};
	localparam bit         DIN [11] = '{0, 0, 0, 0, 1, 1, 0, 0, 1, 0, 0};
	localparam bit         DOUT [11] = '{1, 0, 1, 0, 0, 0, 0, 0, 0, 1, 1};
	localparam bit         DEFER [11] = '{0, 0, 0, 0, 1, 1, 1, 0, 1, 0, 0};
	localparam logic [7:0] ID = 8'hA5; // Arbitrary identification value
	logic             clk_sys_in = 1'b0;
	logic             resetn_in = 1'b0;
	logic             cmd_valid = 1'b0, cmd_more = 1'b0, wr_valid = 1'b0, wr_last = 1'b0, hold = 1'b0;
	nfc_pkg::nfc_op_t cmd_op = nfc_pkg::OP_STATUS;
	logic [11:0]      cmd_col = 12'h000, cmd_len = 12'h000;
	logic [17:0]      cmd_row = 18'h00000, src_row = 18'h00000;
	logic [7:0]       wr_data = 8'h00, conf = 8'h10;
	logic [7:0]       rd_data, io_o, m_io;
	logic             ready, refused, done, wr_ready, rd_valid, busy, oe, cle, ale, ce_n, we_n, os_n, m_busy, wp_n;
	wire  [7:0]       io_w = oe ? io_o : m_io;
	wire              rb_w = !(m_busy || hold);
	logic [10:0]      exp_q [$];
	logic [7:0]       shadow [int];
	int               n_fail = 0, comparisons = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	nfc_host i_nfc_host (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
		.cmd_op_in(cmd_op), .cmd_col_in(cmd_col), .cmd_row_in(cmd_row), .cmd_len_in(cmd_len), .cmd_more_in(cmd_more),
		.cmd_ready_out(ready), .cmd_refused_out(refused), .done_out(done), .wr_valid_in(wr_valid),
		.wr_data_in(wr_data), .wr_last_in(wr_last), .wr_ready_out(wr_ready), .rd_valid_out(rd_valid),
		.rd_data_out(rd_data), .dev_busy_out(busy), .nand_io_in(io_w), .nand_io_out(io_o), .nand_io_oe_out(oe),
		.nand_cle_out(cle), .nand_ale_out(ale), .nand_ce_n_out(ce_n), .nand_we_n_out(we_n),
		.output_strobe_n_out(os_n), .nand_wp_n_out(wp_n), .nand_rb_n_in(rb_w));
	nfc_nand_model #(.ID_BYTE(ID)) i_nfc_nand_model (.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
		.output_strobe_n_in(os_n), .rb_in(rb_w), .io_in(io_w), .io_out(m_io), .busy_out(m_busy));
	task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic take(input logic [10:0] seen);
		logic [10:0] e;
		e = (exp_q.size() != 0) ? exp_q.pop_front() : 11'h7FF;
		check("pin cycle or read byte", seen, e);
	endtask
	always @(posedge we_n) if (ce_n === 1'b0) take({1'b0, cle, ale, io_w});
	always @(posedge clk_sys_in) if (rd_valid === 1'b1) take({3'h4, rd_data});
	task automatic until_high(input int s);
		int i;
		for (i = 0; i < 4000; i++) begin
			@(posedge clk_sys_in);
			if ((s == 0 && ready === 1'b1) || (s == 1 && wr_ready === 1'b1) || (s == 2 && done === 1'b1))
				break;
		end
		check("handshake wait", 11'(i == 4000), 11'h000);
	endtask
	task automatic run(input nfc_pkg::nfc_op_t op, input logic [11:0] col, input logic [17:0] row, input int n,
			input logic more);
		logic [7:0] ab [5];
		logic [7:0] c2;
		logic [7:0] d;
		logic       refuse;
		ab = '{col[7:0], {4'h0, col[11:8]}, row[7:0], row[15:8], {6'h00, row[17:16]}};
		refuse = hold && !(op inside {nfc_pkg::OP_RESET, nfc_pkg::OP_STATUS});
		c2 = (op == nfc_pkg::OP_RAND_IN) ? conf : C2[op];
		if (!refuse) begin
			exp_q.push_back({3'h2, C1[op]});
			for (int k = 0; k < NA[op]; k++)
				exp_q.push_back({3'h1, ab[(op == nfc_pkg::OP_ERASE) ? k + 2 : k]});
		end
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_col = col;
		cmd_row = row;
		cmd_len = 12'(n);
		cmd_more = more;
		until_high(0);
		#1;
		cmd_valid = 1'b0;
		check("refused", {10'h000, refused}, {10'h000, refuse});
		for (int k = 0; k < n && !refuse && DIN[op]; k++) begin
			d = 8'($urandom);
			shadow[{row, 12'(col + k)}] = d;
			exp_q.push_back({3'h0, d});
			wr_valid = 1'b1;
			wr_data = d;
			wr_last = (k == n - 1);
			until_high(1);
			#1;
		end
		wr_valid = 1'b0;
		if (!refuse && c2 != 8'h00 && !(more && DEFER[op]))
			exp_q.push_back({3'h2, c2});
		for (int k = 0; k < n && !refuse && DOUT[op]; k++) begin
			d = shadow.exists({row, 12'(col + k)}) ? shadow[{row, 12'(col + k)}] : 8'(col + k);
			if (op == nfc_pkg::OP_READ_ID)
				d = ID + 8'(k);
			if (op == nfc_pkg::OP_STATUS)
				d = {1'b1, !hold, 6'h00};
			exp_q.push_back({3'h4, d});
		end
		if (!refuse && op inside {nfc_pkg::OP_PROG, nfc_pkg::OP_PROG_CACHE, nfc_pkg::OP_COPY_PROG})
			conf = C2[op];
		if (!refuse && op == nfc_pkg::OP_READ_COPY)
			src_row = row;
		for (int k = 0; k < 2112 && !refuse && op == nfc_pkg::OP_COPY_PROG; k++)
			if (shadow.exists({src_row, 12'(k)}))
				shadow[{row, 12'(k)}] = shadow[{src_row, 12'(k)}];
			else
				shadow.delete({row, 12'(k)});
		for (int k = 0; k < 64 * 2112 && !refuse && op == nfc_pkg::OP_ERASE; k++)
			shadow.delete({row[17:6], 6'(k / 2112), 12'(k % 2112)});
		// A refused request still lets an edge pass before the next one
		if (!refuse)
			until_high(2);
		else
			@(posedge clk_sys_in);
		#1;
	endtask
	task automatic summarize();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		n_fail++;
		summarize();
	end
	initial begin
		logic [11:0] c;
		logic [17:0] r, s;
		void'($urandom(36395));
		c = 12'($urandom % 2000);
		r = 18'($urandom);
		s = 18'($urandom);
		repeat (6) @(posedge clk_sys_in);
		#1;
		resetn_in = 1'b1;
		@(posedge clk_sys_in);
		#1;
		check("write protect", 11'(wp_n), 11'h001);
		run(nfc_pkg::OP_STATUS, 12'h000, r, 1, 1'b0);
		// Last two spare columns, read back, then a column move
		run(nfc_pkg::OP_PROG, 12'h83E, r, 2, 1'b0);
		run(nfc_pkg::OP_READ, 12'h83E, r, 2, 1'b0);
		run(nfc_pkg::OP_RAND_OUT, 12'h83F, r, 1, 1'b0);
		run(nfc_pkg::OP_PROG, c, s, 3, 1'b1);
		run(nfc_pkg::OP_RAND_IN, c + 12'h008, s, 2, 1'b0);
		run(nfc_pkg::OP_READ, c, s, 10, 1'b0);
		run(nfc_pkg::OP_PROG_CACHE, c, r, 2, 1'b1);
		run(nfc_pkg::OP_RAND_IN, c + 12'h004, r, 1, 1'b0);
		run(nfc_pkg::OP_READ_COPY, 12'h000, r, 0, 1'b0);
		run(nfc_pkg::OP_COPY_PROG, 12'h000, s, 0, 1'b0);
		run(nfc_pkg::OP_READ, c, s, 10, 1'b0);
		run(nfc_pkg::OP_ERASE, 12'h000, s, 0, 1'b0);
		run(nfc_pkg::OP_READ, c, s, 2, 1'b0);
		run(nfc_pkg::OP_READ_ID, 12'h000, r, 2, 1'b0);
		run(nfc_pkg::OP_RESET, 12'h000, r, 0, 1'b0);
		// Device held busy from outside: only status and reset may pass
		check("busy flag", 11'(busy), 11'h000);
		hold = 1'b1;
		repeat (6) @(posedge clk_sys_in);
		#1;
		check("busy flag", 11'(busy), 11'h001);
		run(nfc_pkg::OP_PROG, c, r, 1, 1'b0);
		run(nfc_pkg::OP_STATUS, 12'h000, r, 1, 1'b0);
		fork
			#1000 hold = 1'b0;
		join_none
		run(nfc_pkg::OP_RESET, 12'h000, r, 0, 1'b0);
		check("pending cycles", 11'(exp_q.size()), 11'h000);
		summarize();
	end
endmodule
